//--- src/rftc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rftc_top (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire rftc_pkg::rftc_cmd_s  cmd,
  output logic                      cmd_error,
  input  wire logic                 meas_valid,
  input  wire rftc_pkg::rftc_meas_s meas,
  input  wire logic                 func_dual,
  input  wire rftc_pkg::rftc_page_e page,
  output logic                      rep_valid,
  input  wire logic                 rep_ready,
  output rftc_pkg::rftc_item_s      rep_item,
  output logic                      auto_on,
  output logic                      corr_on,
  output logic                      conv_on,
  output rftc_pkg::rftc_sens_e      sensor_sel,
  output logic                      acal_apply,
  output rftc_pkg::rftc_acal_s      acal_pts,
  output rftc_pkg::rftc_val_t       corr_ref_t,
  output rftc_pkg::rftc_val_t       corr_coef,
  output rftc_pkg::rftc_val_t       conv_r0,
  output rftc_pkg::rftc_val_t       conv_t0,
  output rftc_pkg::rftc_val_t       conv_k
);
  import rftc_pkg::*;

  typedef enum logic {ST_IDLE, ST_SEND} rftc_st_e;
  logic       rst_meta_q;
  logic       rst_n_q;
  rftc_st_e   st_q;
  rftc_item_s slot_q [NSLOT];
  rftc_item_s slot_d [NSLOT];
  logic [1:0] idx_q;
  logic       has_data_q;
  rftc_meas_s last_q;
  logic       pend_q;
  logic       param_ok;
  logic       take;
  logic       accept;
  logic       launch_push;
  logic       load;
  rftc_item_s fi [NSLOT];
  logic       fetch_page_ok;
  rftc_item_s ci [NSLOT];
  logic       cmd_has_rep;
  logic       item_done;
  rftc_val_t  stat_code;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  rftc_range_chk u_chk (
    .cmd      (cmd),
    .param_ok (param_ok)
  );

  // Commands only while idle with no push waiting, so pushes cannot starve
  assign cmd_ready   = rst_n_q && (st_q == ST_IDLE) && !pend_q;
  assign take        = cmd_valid && cmd_ready;
  assign accept      = take && param_ok;
  assign cmd_error   = take && !param_ok;
  assign launch_push = rst_n_q && (st_q == ST_IDLE) && pend_q;
  assign item_done   = rep_valid && rep_ready;

  // Latest result from the measurement engine
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      has_data_q <= 1'b0;
      last_q     <= '0;
    end else if (meas_valid) begin
      has_data_q <= 1'b1;
      last_q     <= meas;
    end
  end

  // Push request; a new result in the launch cycle re-arms it
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q <= 1'b0;
    end else if (meas_valid && auto_on) begin
      pend_q <= 1'b1;
    end else if (launch_push || !auto_on) begin
      pend_q <= 1'b0;
    end
  end

  // On/off states, the two temperature modes exclude each other
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      auto_on <= RST_ONOFF;
      corr_on <= RST_ONOFF;
      conv_on <= RST_ONOFF;
    end else if (accept) begin
      case (cmd.code)
        CMD_AUTO_SET:
          auto_on <= (cmd.arg_char == CHAR_ON);
        CMD_CORR_STATE_SET: begin
          corr_on <= (cmd.arg_char == CHAR_ON);
          if (cmd.arg_char == CHAR_ON) begin
            conv_on <= 1'b0;
          end
        end
        CMD_CONV_STATE_SET: begin
          conv_on <= (cmd.arg_char == CHAR_ON);
          if (cmd.arg_char == CHAR_ON) begin
            corr_on <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // Numeric parameters, written only after the range check passed
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      corr_ref_t <= RST_VAL;
      corr_coef  <= RST_VAL;
      conv_r0    <= RST_VAL;
      conv_t0    <= RST_VAL;
      conv_k     <= RST_VAL;
      sensor_sel <= SENS_PLATINUM_PROBE_INPUT;
      acal_pts   <= '0;
    end else if (accept) begin
      case (cmd.code)
        CMD_CORR_PAR_SET: begin
          corr_ref_t <= cmd.p0;
          corr_coef  <= cmd.p1;
        end
        CMD_CONV_PAR_SET: begin
          conv_r0 <= cmd.p0;
          conv_t0 <= cmd.p1;
          conv_k  <= cmd.p2;
        end
        CMD_SENSOR_SET:
          sensor_sel <= cmd.p0[0] ? SENS_ANALOG
                                  : SENS_PLATINUM_PROBE_INPUT;
        CMD_ACAL_SET:
          acal_pts <= '{cmd.p0, cmd.p1, cmd.p2, cmd.p3};
        default: ;
      endcase
    end
  end

  // Calibration is gated by the sensor choice
  assign acal_apply = (sensor_sel == SENS_ANALOG);

  // Fetch reply from the latest result
  always_comb begin
    fi = '{default: '0};
    fetch_page_ok = (page <= PAGE_STATS); // Listed pages code first
    stat_code = !has_data_q       ? STAT_NODATA
              : last_q.status_err ? STAT_ERR : STAT_OK;
    fi[0].fmt = FMT_EXPONENT_NUMBER_FORMAT;
    if (!has_data_q || last_q.primary_err) begin
      fi[0].fmt = FMT_SENTINEL;
    end else if (conv_on && page == PAGE_RESULT) begin
      fi[0].val = last_q.delta_t;
    end else begin
      fi[0].val = last_q.primary;
    end
    if (func_dual) begin
      fi[1].fmt = (!has_data_q || last_q.secondary_err) ? FMT_SENTINEL
                  : FMT_EXPONENT_NUMBER_FORMAT;
      fi[1].val = last_q.secondary;
      fi[2].fmt = FMT_INTEGER_NUMBER_FORMAT;
      fi[2].val = stat_code;
      fi[2].last = 1'b1;
    end else begin
      fi[1].fmt = FMT_INTEGER_NUMBER_FORMAT;
      fi[1].val = stat_code;
      fi[1].last = 1'b1;
    end
  end

  // Query replies for the settings
  always_comb begin
    ci = '{default: '0};
    cmd_has_rep = 1'b1;
    case (cmd.code)
      CMD_FETCH_Q: begin
        ci = fi;
        cmd_has_rep = fetch_page_ok;
      end
      CMD_CORR_STATE_Q:
        ci[0] = '{FMT_CHAR, {32'h0, corr_on ? CHAR_ON : CHAR_OFF}, 1'b1};
      CMD_CONV_STATE_Q:
        ci[0] = '{FMT_CHAR, {32'h0, conv_on ? CHAR_ON : CHAR_OFF}, 1'b1};
      CMD_CORR_PAR_Q: begin
        ci[0] = '{FMT_DECIMAL1, corr_ref_t, 1'b0};
        ci[1] = '{FMT_INTEGER_NUMBER_FORMAT, corr_coef, 1'b1};
      end
      CMD_CONV_PAR_Q: begin
        ci[0] = '{FMT_EXPONENT_NUMBER_FORMAT, conv_r0, 1'b0};
        ci[1] = '{FMT_DECIMAL1, conv_t0, 1'b0};
        ci[2] = '{FMT_DECIMAL1, conv_k, 1'b1};
      end
      CMD_SENSOR_Q:
        ci[0] = '{FMT_SENSOR, {39'h0, sensor_sel}, 1'b1};
      CMD_ACAL_Q: begin
        ci[0] = '{FMT_DECIMAL2, acal_pts.v1, 1'b0};
        ci[1] = '{FMT_DECIMAL1, acal_pts.t1, 1'b0};
        ci[2] = '{FMT_DECIMAL2, acal_pts.v2, 1'b0};
        ci[3] = '{FMT_DECIMAL1, acal_pts.t2, 1'b1};
      end
      default:
        cmd_has_rep = 1'b0;
    endcase
  end

  // Slot source: an accepted query, else a push on a listed page
  assign load = (accept && cmd_has_rep) || (launch_push && fetch_page_ok);
  always_comb begin
    for (int i = 0; i < NSLOT; i++) begin
      slot_d[i] = take ? ci[i] : fi[i];
    end
  end

  // Reply slots held in flops, one per entry
  for (genvar g = 0; g < NSLOT; g++) begin : g_slot
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
        slot_q[g] <= '0;
      end else if (load) begin
        slot_q[g] <= slot_d[g];
      end
    end
  end

  // Reply sequencer, one field per handshake
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q  <= ST_IDLE;
      idx_q <= 2'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          idx_q <= 2'h0;
          if (load) begin
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (item_done) begin
            idx_q <= idx_q + 2'h1;
            if (slot_q[idx_q].last) begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign rep_valid = (st_q == ST_SEND);
  assign rep_item  = slot_q[idx_q];

  a_mode_excl: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    !(corr_on && conv_on)) else $error("both temperature modes on");

  a_corr_kills: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (accept && cmd.code == CMD_CORR_STATE_SET && cmd.arg_char == CHAR_ON)
    |=> corr_on && !conv_on) else $error("correction on failed");

  a_reject_keep: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    cmd_error |=> $stable(corr_ref_t) && $stable(conv_r0) &&
    $stable(acal_pts) && $stable(sensor_sel))
    else $error("rejected value stored");

  a_page_silent: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (accept && cmd.code == CMD_FETCH_Q && page == PAGE_OTHER)
    |=> !rep_valid) else $error("fetch answered on other page");

  a_single_len: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (accept && cmd.code == CMD_FETCH_Q && fetch_page_ok && !func_dual)
    |=> rep_valid && !rep_item.last && slot_q[1].last)
    else $error("single fetch length wrong");

  a_dual_len: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (accept && cmd.code == CMD_FETCH_Q && fetch_page_ok && func_dual)
    |=> !slot_q[1].last && slot_q[2].last
    && slot_q[2].fmt == FMT_INTEGER_NUMBER_FORMAT)
    else $error("dual fetch length wrong");

  a_sentinel_pri: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (load && take && cmd.code == CMD_FETCH_Q && last_q.primary_err)
    |=> slot_q[0].fmt == FMT_SENTINEL) else $error("no sentinel");

  a_status_nodata: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (load && take && cmd.code == CMD_FETCH_Q && !func_dual && !has_data_q)
    |=> slot_q[1].val == STAT_NODATA) else $error("no-data status");

  a_auto_push: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (meas_valid && auto_on && page == PAGE_RESULT && st_q == ST_IDLE
     && !take) |-> ##[1:3] rep_valid) else $error("push missing");

  a_delta_sel: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (load && take && cmd.code == CMD_FETCH_Q && conv_on &&
     page == PAGE_RESULT && has_data_q && !last_q.primary_err)
    |=> slot_q[0].val == $past(last_q.delta_t))
    else $error("increment not reported");

  a_cal_gate: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (accept && cmd.code == CMD_SENSOR_SET) |=> acal_apply == $past(cmd.p0[0]))
    else $error("calibration gate wrong");

endmodule // rftc_top
`default_nettype wire

//--- include/rftc_pkg.sv
package rftc_pkg;

  // Value word: fixed point, scale depends on the field (see formats)
  localparam int VW = 40;
  typedef logic signed [VW-1:0] rftc_val_t;

  // Host command codes after the text parser
  typedef enum logic [3:0] {
    CMD_FETCH_Q,
    CMD_AUTO_SET,
    CMD_CORR_STATE_SET,
    CMD_CORR_STATE_Q,
    CMD_CORR_PAR_SET,
    CMD_CORR_PAR_Q,
    CMD_CONV_STATE_SET,
    CMD_CONV_STATE_Q,
    CMD_CONV_PAR_SET,
    CMD_CONV_PAR_Q,
    CMD_SENSOR_SET,
    CMD_SENSOR_Q,
    CMD_ACAL_SET,
    CMD_ACAL_Q
  } rftc_cmd_e;

  // Display page currently shown
  typedef enum logic [2:0] {
    PAGE_RESULT,
    PAGE_COMPARE,
    PAGE_BIN,
    PAGE_STATS,
    PAGE_OTHER
  } rftc_page_e;

  // How the reply formatter renders one field
  typedef enum logic [2:0] {
    FMT_INTEGER_NUMBER_FORMAT,
    FMT_DECIMAL1,
    FMT_DECIMAL2,
    FMT_EXPONENT_NUMBER_FORMAT,
    FMT_CHAR,
    FMT_SENTINEL,
    FMT_SENSOR
  } rftc_fmt_e;

  typedef enum logic {
    SENS_PLATINUM_PROBE_INPUT,
    SENS_ANALOG
  } rftc_sens_e;

  typedef struct packed {
    rftc_cmd_e code;
    logic [7:0] arg_char;
    rftc_val_t p0;
    rftc_val_t p1;
    rftc_val_t p2;
    rftc_val_t p3;
  } rftc_cmd_s;

  typedef struct packed {
    rftc_fmt_e fmt;
    rftc_val_t val;
    logic last;
  } rftc_item_s;

  typedef struct packed {
    rftc_val_t primary;
    rftc_val_t secondary;
    rftc_val_t delta_t;
    logic primary_err;
    logic secondary_err;
    logic status_err;
  } rftc_meas_s;

  typedef struct packed {
    rftc_val_t v1;
    rftc_val_t t1;
    rftc_val_t v2;
    rftc_val_t t2;
  } rftc_acal_s;

  // On/off characters
  localparam logic [7:0] CHAR_ON  = 8'h31;
  localparam logic [7:0] CHAR_OFF = 8'h30;

  // System status codes
  localparam rftc_val_t STAT_NODATA = -40'sh1;
  localparam rftc_val_t STAT_OK     = 40'sh0;
  localparam rftc_val_t STAT_ERR    = 40'sh1;

  // Limits, tenths of a degree, ppm, milliohm, hundredths of a volt
  localparam rftc_val_t TEMP_MIN  = -40'sh64;
  localparam rftc_val_t TEMP_MAX  = 40'sh3E7;
  localparam rftc_val_t COEF_MAX  = 40'sh1869F;
  localparam rftc_val_t R0_MAX    = 40'sh199C82CC00;
  localparam rftc_val_t K_MAX     = 40'sh270F;
  localparam rftc_val_t VOLT_MAX  = 40'shC8;
  localparam rftc_val_t ACAL_TMIN = -40'sh3E7;
  localparam rftc_val_t ACAL_TMAX = 40'sh270F;

  // Reset values
  localparam logic      RST_ONOFF = 1'b0;
  localparam rftc_val_t RST_VAL   = 40'sh0;

  // Reply slots
  localparam int NSLOT = 4;

endpackage

//--- src/rftc_range_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rftc_range_chk (
  input  wire rftc_pkg::rftc_cmd_s cmd,
  output logic                     param_ok
);
  import rftc_pkg::*;

  function automatic logic inr(input rftc_val_t v, input rftc_val_t lo,
                               input rftc_val_t hi);
    inr = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic onoff(input logic [7:0] c);
    onoff = (c == CHAR_ON) || (c == CHAR_OFF);
  endfunction

  // Range check per setting command; queries always pass
  always_comb begin
    case (cmd.code)
      CMD_AUTO_SET, CMD_CORR_STATE_SET, CMD_CONV_STATE_SET:
        param_ok = onoff(cmd.arg_char);
      CMD_CORR_PAR_SET:
        param_ok = inr(cmd.p0, TEMP_MIN, TEMP_MAX) &&
                   inr(cmd.p1, -COEF_MAX, COEF_MAX);
      CMD_CONV_PAR_SET:
        param_ok = inr(cmd.p0, RST_VAL, R0_MAX) &&
                   inr(cmd.p1, TEMP_MIN, TEMP_MAX) &&
                   inr(cmd.p2, -K_MAX, K_MAX);
      CMD_SENSOR_SET:
        param_ok = inr(cmd.p0, RST_VAL, 40'sh1);
      CMD_ACAL_SET:
        param_ok = inr(cmd.p0, RST_VAL, VOLT_MAX) &&
                   inr(cmd.p1, ACAL_TMIN, ACAL_TMAX) &&
                   inr(cmd.p2, RST_VAL, VOLT_MAX) &&
                   inr(cmd.p3, ACAL_TMIN, ACAL_TMAX);
      default:
        param_ok = 1'b1;
    endcase
  end

endmodule // rftc_range_chk
`default_nettype wire

//--- tb/rftc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rftc_host_model (
  input  wire logic                 clk_sys,
  input  wire logic                 slow,
  input  wire logic                 rep_valid,
  input  wire rftc_pkg::rftc_item_s rep_item,
  output logic                      rep_ready
);
  import rftc_pkg::*;

  rftc_item_s q[$];
  logic       tog_q = 1'b0;

  // Collect each field taken; slow mode stalls every other cycle
  always @(posedge clk_sys) begin
    tog_q <= ~tog_q;
    if (rep_valid && rep_ready) begin
      q.push_back(rep_item);
    end
  end

  // Stalling checks that a field is held until it is taken
  assign rep_ready = slow ? tog_q : 1'b1;
endmodule // rftc_host_model
`default_nettype wire

//--- tb/rftc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rftc_top_tb;
  import rftc_pkg::*;

  logic       clk_sys    = 1'b0;
  logic       resetn     = 1'b0;
  logic       cmd_valid  = 1'b0;
  logic       meas_valid = 1'b0;
  logic       func_dual  = 1'b0;
  logic       slow       = 1'b0;
  rftc_cmd_s  cmd        = '0;
  rftc_meas_s meas       = '0;
  rftc_page_e page       = PAGE_RESULT;
  logic       cmd_ready, cmd_error, rep_valid, rep_ready;
  logic       auto_on, corr_on, conv_on, acal_apply, last_err;
  rftc_item_s rep_item;
  rftc_sens_e sensor_sel;
  rftc_acal_s acal_pts;
  rftc_val_t  corr_ref_t, corr_coef, conv_r0, conv_t0, conv_k;
  int         n_fail = 0;
  int         n_checks = 0;
  int         cyc = 0;

  always #20 clk_sys = ~clk_sys;

  rftc_top dut (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .cmd_error(cmd_error),
    .meas_valid(meas_valid), .meas(meas), .func_dual(func_dual),
    .page(page), .rep_valid(rep_valid), .rep_ready(rep_ready),
    .rep_item(rep_item), .auto_on(auto_on), .corr_on(corr_on),
    .conv_on(conv_on), .sensor_sel(sensor_sel), .acal_apply(acal_apply),
    .acal_pts(acal_pts), .corr_ref_t(corr_ref_t), .corr_coef(corr_coef),
    .conv_r0(conv_r0), .conv_t0(conv_t0), .conv_k(conv_k));

  rftc_host_model host (.clk_sys(clk_sys), .slow(slow),
    .rep_valid(rep_valid), .rep_item(rep_item), .rep_ready(rep_ready));

  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [159:0] got, input logic [159:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_item(input int i, input rftc_fmt_e f,
                          input rftc_val_t v, input logic l);
    rftc_item_s x;
    x = 'x;
    if (i < host.q.size()) x = host.q[i];
    chk(x, {f, v, l});
  endtask

  // Wait until idle with no reply field pending, bounded
  task automatic wait_idle();
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_sys);
      if (cmd_ready === 1'b1 && rep_valid === 1'b0) break;
    end
    if (k == 40) n_fail++;
  endtask

  // Command held until taken; cmd_error sampled before the taking edge
  task automatic send(input rftc_cmd_e c, input logic [7:0] ch = 8'h00,
                      input rftc_val_t a = '0, input rftc_val_t b = '0,
                      input rftc_val_t d = '0, input rftc_val_t e = '0);
    host.q.delete();
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd       <= '{c, ch, a, b, d, e};
    wait_idle();
    last_err = cmd_error;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    wait_idle();
  endtask

  task automatic new_meas(input rftc_meas_s m);
    host.q.delete();
    @(posedge clk_sys);
    meas       <= m;
    meas_valid <= 1'b1;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    wait_idle();
  endtask

  task automatic fetch(input rftc_page_e pg, input logic dual);
    @(posedge clk_sys);
    page      <= pg;
    func_dual <= dual;
    send(CMD_FETCH_Q);
  endtask

  task automatic t_reset();
    chk({corr_on, conv_on, auto_on, acal_apply}, 4'h0);
    chk(sensor_sel, SENS_PLATINUM_PROBE_INPUT);
    fetch(PAGE_RESULT, 1'b0);
    chk_item(0, FMT_SENTINEL, 40'h0, 1'b0);
    chk_item(1, FMT_INTEGER_NUMBER_FORMAT, STAT_NODATA, 1'b1);
  endtask

  task automatic t_states();
    send(CMD_CORR_STATE_SET, CHAR_ON);
    chk({corr_on, conv_on}, 2'h2);
    send(CMD_CONV_STATE_SET, CHAR_ON);
    chk({corr_on, conv_on}, 2'h1);
    send(CMD_CONV_STATE_Q);
    chk_item(0, FMT_CHAR, 40'h31, 1'b1);
    send(CMD_CORR_STATE_Q);
    chk_item(0, FMT_CHAR, 40'h30, 1'b1);
    send(CMD_CORR_STATE_SET, 8'h32);
    chk({last_err, corr_on, conv_on}, 3'h5);
    send(CMD_CORR_STATE_SET, CHAR_ON);
    chk({corr_on, conv_on}, 2'h2);
    send(CMD_CORR_STATE_SET, CHAR_OFF);
    chk(corr_on, 1'b0);
  endtask

  task automatic t_params();
    send(CMD_CORR_PAR_SET, 8'h00, TEMP_MAX, -COEF_MAX);
    chk({corr_ref_t, corr_coef}, {TEMP_MAX, -COEF_MAX});
    send(CMD_CORR_PAR_SET, 8'h00, TEMP_MIN - 1, COEF_MAX);
    chk({last_err, corr_ref_t}, {1'b1, TEMP_MAX});
    send(CMD_CORR_PAR_Q);
    chk_item(0, FMT_DECIMAL1, TEMP_MAX, 1'b0);
    chk_item(1, FMT_INTEGER_NUMBER_FORMAT, -COEF_MAX, 1'b1);
    send(CMD_CONV_PAR_SET, 8'h00, R0_MAX, TEMP_MIN, -K_MAX);
    chk({conv_r0, conv_t0, conv_k}, {R0_MAX, TEMP_MIN, -K_MAX});
    send(CMD_CONV_PAR_SET, 8'h00, R0_MAX + 1, 40'h0, 40'h0);
    chk({last_err, conv_r0}, {1'b1, R0_MAX});
    slow <= 1'b1;
    send(CMD_CONV_PAR_Q);
    chk_item(0, FMT_EXPONENT_NUMBER_FORMAT, R0_MAX, 1'b0);
    chk_item(1, FMT_DECIMAL1, TEMP_MIN, 1'b0);
    chk_item(2, FMT_DECIMAL1, -K_MAX, 1'b1);
  endtask

  task automatic t_sensor();
    send(CMD_SENSOR_SET, 8'h00, 40'h1);
    chk({sensor_sel, acal_apply}, 2'h3);
    send(CMD_SENSOR_SET, 8'h00, 40'h2);
    chk({last_err, sensor_sel}, 2'h3);
    send(CMD_SENSOR_Q);
    chk_item(0, FMT_SENSOR, 40'h1, 1'b1);
    send(CMD_ACAL_SET, 8'h00, VOLT_MAX, ACAL_TMIN, 40'h0, ACAL_TMAX);
    chk(acal_pts, {VOLT_MAX, ACAL_TMIN, 40'h0, ACAL_TMAX});
    send(CMD_ACAL_SET, 8'h00, VOLT_MAX + 1, 40'h0, 40'h0, 40'h0);
    chk({last_err, acal_pts.v1}, {1'b1, VOLT_MAX});
    send(CMD_ACAL_Q);
    chk_item(0, FMT_DECIMAL2, VOLT_MAX, 1'b0);
    chk_item(1, FMT_DECIMAL1, ACAL_TMIN, 1'b0);
    chk_item(2, FMT_DECIMAL2, 40'h0, 1'b0);
    chk_item(3, FMT_DECIMAL1, ACAL_TMAX, 1'b1);
    send(CMD_SENSOR_SET, 8'h00, 40'h0);
    chk({sensor_sel, acal_apply}, 2'h0);
  endtask

  task automatic t_fetch();
    new_meas('{40'h7B, 40'h2A, 40'h5, 1'b0, 1'b0, 1'b0});
    fetch(PAGE_STATS, 1'b0);
    chk_item(0, FMT_EXPONENT_NUMBER_FORMAT, 40'h7B, 1'b0);
    chk_item(1, FMT_INTEGER_NUMBER_FORMAT, STAT_OK, 1'b1);
    fetch(PAGE_BIN, 1'b1);
    chk_item(1, FMT_EXPONENT_NUMBER_FORMAT, 40'h2A, 1'b0);
    chk_item(2, FMT_INTEGER_NUMBER_FORMAT, STAT_OK, 1'b1);
    new_meas('{40'h7B, 40'h2A, 40'h5, 1'b0, 1'b1, 1'b1});
    fetch(PAGE_COMPARE, 1'b1);
    chk_item(1, FMT_SENTINEL, 40'h2A, 1'b0);
    chk_item(2, FMT_INTEGER_NUMBER_FORMAT, STAT_ERR, 1'b1);
    new_meas('{40'h7B, 40'h2A, 40'h5, 1'b1, 1'b0, 1'b0});
    fetch(PAGE_RESULT, 1'b0);
    chk_item(0, FMT_SENTINEL, 40'h0, 1'b0);
    send(CMD_CONV_STATE_SET, CHAR_ON);
    new_meas('{40'h7B, 40'h2A, 40'h5, 1'b0, 1'b0, 1'b0});
    fetch(PAGE_RESULT, 1'b0);
    chk_item(0, FMT_EXPONENT_NUMBER_FORMAT, 40'h5, 1'b0);
    fetch(PAGE_COMPARE, 1'b0);
    chk_item(0, FMT_EXPONENT_NUMBER_FORMAT, 40'h7B, 1'b0);
    fetch(PAGE_OTHER, 1'b0);
    chk(host.q.size(), 0);
  endtask

  task automatic t_auto();
    send(CMD_AUTO_SET, CHAR_ON);
    chk(auto_on, 1'b1);
    @(posedge clk_sys);
    page <= PAGE_RESULT;
    new_meas('{40'h99, 40'h0, 40'h6, 1'b0, 1'b0, 1'b0});
    chk(host.q.size(), 2);
    chk_item(0, FMT_EXPONENT_NUMBER_FORMAT, 40'h6, 1'b0);
    send(CMD_CONV_STATE_SET, CHAR_OFF);
    new_meas('{40'h9A, 40'h0, 40'h0, 1'b0, 1'b0, 1'b0});
    chk_item(0, FMT_EXPONENT_NUMBER_FORMAT, 40'h9A, 1'b0);
    send(CMD_AUTO_SET, CHAR_OFF);
    new_meas('{40'h77, 40'h0, 40'h0, 1'b0, 1'b0, 1'b0});
    chk({auto_on, 32'(host.q.size())}, 33'h0);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_states();
    t_params();
    t_sensor();
    t_fetch();
    t_auto();
    give_verdict();
  end
endmodule // rftc_top_tb
`default_nettype wire
